// ===== rtl/pfb_pkg.sv
// Package with pin widths, timing figures and cycle counts for the page flash bus host.
package pfb_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned HALF_W = 16;
   localparam int unsigned PAGE_LO_BIT = 2;
   localparam int unsigned TOP_PIN = 31;
   localparam int unsigned RANDOM_ACCESS_TIME_NS = 70;
   localparam int unsigned PAGE_ACCESS_TIME_NS = 25;
   localparam int unsigned SELECT_ACCESS_TIME_NS = 70;
   localparam int unsigned WRITE_PULSE_NS = 35;
   localparam int unsigned RECOVERY_NS = 20;
   localparam int unsigned RANDOM_CYC = (RANDOM_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PAGE_CYC = (PAGE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SELECT_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVERY_CYC = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SYNC_CYC = 2;
   localparam int unsigned CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   localparam logic [19:0] ADDR_ZERO = 20'h0_0000;
   typedef enum logic [4:0] {
      PFB_IDLE = 5'b0_0001,
      PFB_RD = 5'b0_0010,
      PFB_WR = 5'b0_0100,
      PFB_REC = 5'b0_1000,
      PFB_DONE = 5'b1_0000
   } pfb_state_t;
endpackage

// ===== rtl/pfb_wait_cnt.sv
// Down counter that times one access phase in clock cycles.
module pfb_wait_cnt (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_en,
   input wire logic i_load,
   input wire logic [3:0] i_count,
   output logic o_zero
);
   logic [3:0] cnt_ff;

   // Loads a count, then counts down to zero and holds there.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= pfb_pkg::CNT_ZERO;
      end else if (i_en) begin
         if (i_load) begin
            cnt_ff <= i_count;
         end else if (cnt_ff != pfb_pkg::CNT_ZERO) begin
            cnt_ff <= cnt_ff - 4'h1;
         end
      end
   end

   assign o_zero = (cnt_ff == pfb_pkg::CNT_ZERO);
endmodule

// ===== rtl/pfb_host.sv
// Host controller that drives the page mode flash through its strobes, address and data pins.
// Overview of operation
// - Read by driving select and gate low.
// - Hold write strobe high while reading.
// - Address bits 19..0, plus low half.
// - Word mode: bits 1..0 pick word.
// - Half mode: A1,A0,low half pick word.
// - Write with strobe, select low, gate high.
module pfb_host (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic i_half_mode,
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic [20:0] i_req_addr,
   input wire logic [31:0] i_req_wdata,
   input wire logic i_req_keep_select,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [31:0] o_rsp_rdata,
   output logic o_chip_select_n,
   output logic o_output_gate_n,
   output logic o_write_strobe_n,
   output logic o_width_select_n,
   output logic [19:0] o_addr,
   output logic [31:0] o_data_out,
   output logic [31:0] o_data_oe,
   input wire logic [31:0] i_data_in
);
   pfb_pkg::pfb_state_t state_ff;
   pfb_pkg::pfb_state_t nxt_state;
   logic sel_ff;
   logic gate_ff;
   logic wr_ff;
   logic half_ff;
   logic [19:0] addr_ff;
   logic low_half_ff;
   logic [31:0] wdata_ff;
   logic [31:0] rdata_ff;
   logic page_valid_ff;
   logic [17:0] page_ff;
   logic [31:0] din_meta_ff;
   logic [31:0] din_sync_ff;
   logic load;
   logic [3:0] load_count;
   logic wait_done;
   logic hit;

   // Page of a request is formed from address bits 19 down to 2, or 20 down to 3 in half mode.
   function automatic logic [17:0] page_of(input logic [20:0] a, input logic half);
      page_of = half ? a[20:3] : a[19:2];
   endfunction

   // Word address on the pins, with the extra low bit split out in half mode.
   function automatic logic [19:0] pins_of(input logic [20:0] a, input logic half);
      pins_of = half ? a[20:1] : a[19:0];
   endfunction

   pfb_wait_cnt u_wait (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_en(i_clk_en),
      .i_load(load),
      .i_count(load_count),
      .o_zero(wait_done)
   );

   assign hit = page_valid_ff && sel_ff && !i_req_write && (page_of(i_req_addr, half_ff) == page_ff);

   // Chooses the next phase and the length of its wait.
   always_comb begin
      nxt_state = state_ff;
      load = 1'b0;
      load_count = pfb_pkg::CNT_ZERO;
      case (state_ff)
         pfb_pkg::PFB_IDLE: begin
            if (i_req) begin
               load = 1'b1;
               if (i_req_write) begin
                  nxt_state = pfb_pkg::PFB_WR;
                  load_count = 4'(pfb_pkg::WRITE_CYC);
               end else begin
                  nxt_state = pfb_pkg::PFB_RD;
                  // Full time on a new page or after select rose, short time on a hit.
                  // The wait also covers the two stages of the data pin synchroniser.
                  load_count = hit ? 4'(pfb_pkg::PAGE_CYC + pfb_pkg::SYNC_CYC) :
                     4'(pfb_pkg::RANDOM_CYC + pfb_pkg::SYNC_CYC);
               end
            end
         end
         pfb_pkg::PFB_RD: begin
            if (wait_done && !load) begin
               nxt_state = pfb_pkg::PFB_DONE;
            end
         end
         pfb_pkg::PFB_WR: begin
            if (wait_done) begin
               nxt_state = pfb_pkg::PFB_REC;
               load = 1'b1;
               load_count = 4'(pfb_pkg::RECOVERY_CYC);
            end
         end
         pfb_pkg::PFB_REC: begin
            if (wait_done) begin
               nxt_state = pfb_pkg::PFB_DONE;
            end
         end
         pfb_pkg::PFB_DONE: begin
            nxt_state = pfb_pkg::PFB_IDLE;
         end
         default: begin
            nxt_state = pfb_pkg::PFB_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_ff <= pfb_pkg::PFB_IDLE;
      end else if (i_clk_en) begin
         state_ff <= nxt_state;
      end
   end

   // Strobe levels for each phase.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sel_ff <= 1'b0;
         gate_ff <= 1'b0;
         wr_ff <= 1'b0;
      end else if (i_clk_en) begin
         case (nxt_state)
            pfb_pkg::PFB_RD: begin
               sel_ff <= 1'b1;
               gate_ff <= 1'b1;
               wr_ff <= 1'b0;
            end
            pfb_pkg::PFB_WR: begin
               sel_ff <= 1'b1;
               gate_ff <= 1'b0;
               wr_ff <= 1'b1;
            end
            pfb_pkg::PFB_REC: begin
               gate_ff <= 1'b0;
               wr_ff <= 1'b0;
            end
            pfb_pkg::PFB_DONE: begin
               gate_ff <= 1'b0;
               wr_ff <= 1'b0;
               // Dropping select ends page reuse on the next access.
               sel_ff <= i_req_keep_select && (state_ff == pfb_pkg::PFB_RD);
            end
            default: begin
               gate_ff <= 1'b0;
               wr_ff <= 1'b0;
            end
         endcase
      end
   end

   // Address and write data are captured when a request is taken, mode while idle without a request.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         addr_ff <= pfb_pkg::ADDR_ZERO;
         low_half_ff <= 1'b0;
         half_ff <= 1'b0;
         wdata_ff <= pfb_pkg::DATA_ZERO;
      end else if (i_clk_en) begin
         if (state_ff == pfb_pkg::PFB_IDLE && !i_req) begin
            half_ff <= i_half_mode;
         end
         if (state_ff == pfb_pkg::PFB_IDLE && i_req) begin
            addr_ff <= pins_of(i_req_addr, half_ff);
            low_half_ff <= i_req_addr[0];
            wdata_ff <= i_req_wdata;
         end
      end
   end

   // Remembers the open page while select stays low after a read.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         page_valid_ff <= 1'b0;
         page_ff <= 18'h0_0000;
      end else if (i_clk_en) begin
         if (state_ff == pfb_pkg::PFB_IDLE && i_req && !i_req_write) begin
            page_valid_ff <= 1'b1;
            page_ff <= page_of(i_req_addr, half_ff);
         end else if (!sel_ff || state_ff == pfb_pkg::PFB_WR) begin
            page_valid_ff <= 1'b0;
         end
      end
   end

   // Data pins pass two flip-flops before the read value is taken.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         din_meta_ff <= pfb_pkg::DATA_ZERO;
         din_sync_ff <= pfb_pkg::DATA_ZERO;
      end else if (i_clk_en) begin
         din_meta_ff <= i_data_in;
         din_sync_ff <= din_meta_ff;
      end
   end

   // Read data is the full word, or the low half in half mode.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_ff <= pfb_pkg::DATA_ZERO;
      end else if (i_clk_en && state_ff == pfb_pkg::PFB_RD && wait_done) begin
         rdata_ff <= half_ff ? {16'h0000, din_sync_ff[15:0]} : din_sync_ff;
      end
   end

   assign o_chip_select_n = !sel_ff;
   assign o_output_gate_n = !gate_ff;
   assign o_write_strobe_n = !wr_ff;
   assign o_width_select_n = !half_ff;
   assign o_addr = addr_ff;
   // Top pin carries the low half address in half mode, upper pins stay undriven then.
   assign o_data_out = half_ff ? {low_half_ff, 15'h0000, wdata_ff[15:0]} : wdata_ff;
   assign o_data_oe = half_ff ? {1'b1, 15'h0000, {16{wr_ff}}} : {32{wr_ff}};
   assign o_req_ready = (state_ff == pfb_pkg::PFB_IDLE);
   assign o_rsp_valid = (state_ff == pfb_pkg::PFB_DONE);
   assign o_rsp_rdata = rdata_ff;
endmodule

// ===== tb/pfb_host_props.sv
// Assertions on the host pin levels and response handshake.
module pfb_host_props (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire logic o_chip_select_n,
   input wire logic o_output_gate_n,
   input wire logic o_write_strobe_n,
   input wire logic o_width_select_n,
   input wire logic [31:0] o_data_oe
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   property p_rsel; !o_output_gate_n |-> !o_chip_select_n; endproperty
   a_rsel: assert property (p_rsel) else $error("gate without select");
   property p_rwe; !o_output_gate_n |-> o_write_strobe_n; endproperty
   a_rwe: assert property (p_rwe) else $error("strobe during read");
   property p_wr; !o_write_strobe_n |-> o_output_gate_n && !o_chip_select_n; endproperty
   a_wr: assert property (p_wr) else $error("bad write levels");
   property p_coll;
      !o_output_gate_n |-> o_data_oe[30:0] == 31'h0000_0000 && o_data_oe[31] == !o_width_select_n;
   endproperty
   a_coll: assert property (p_coll) else $error("drive during read");
   property p_half; !o_width_select_n |-> o_data_oe[31] && o_data_oe[30:16] == 15'h0000; endproperty
   a_half: assert property (p_half) else $error("half mode drive");
   property p_full; o_width_select_n && o_write_strobe_n |-> o_data_oe == 32'h0000_0000; endproperty
   a_full: assert property (p_full) else $error("idle drive");
   property p_wlen; $fell(o_write_strobe_n) |-> !o_write_strobe_n [*4]; endproperty
   a_wlen: assert property (p_wlen) else $error("short write");
   property p_done; o_rsp_valid |=> !o_rsp_valid && o_req_ready; endproperty
   a_done: assert property (p_done) else $error("long response");
   c_rd: cover property (!o_output_gate_n);
   c_wr: cover property (!o_write_strobe_n);
   c_half: cover property (!o_width_select_n && !o_output_gate_n);
endmodule

bind pfb_host pfb_host_props u_pfb_host_props (.i_ref_clk, .i_rst_b, .o_req_ready, .o_rsp_valid,
   .o_chip_select_n, .o_output_gate_n, .o_write_strobe_n, .o_width_select_n, .o_data_oe);

// ===== tb/pfb_flash_model.sv
// Pin level model of the page mode flash in array read mode.
module pfb_flash_model (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_cs_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_ws_n,
   input wire logic [19:0] i_addr,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_dq
);
   logic [3:0] cnt_ff;
   logic hit_ff;
   logic [20:0] el_ff;
   logic [31:0] last_ff, cmd_ff, dw, mk;
   wire logic lsb = !i_ws_n & i_wdata[31];
   wire logic [20:0] el = {i_addr, lsb};
   wire logic rdy = cnt_ff >= (hit_ff ? 4'(pfb_pkg::PAGE_CYC) : 4'(pfb_pkg::RANDOM_CYC));
   always_comb begin
      dw = 32'hC3A0_0000 | {12'h000, i_addr};
      if (!i_ws_n) dw = {16'h0000, lsb ? dw[31:16] : dw[15:0]};
      mk = i_ws_n ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      o_dq = (!i_cs_n && !i_oe_n && i_we_n && rdy) ? (dw & mk) | (~last_ff & ~mk) : ~last_ff;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         el_ff <= 21'h00_0000;
         last_ff <= 32'h0000_0000;
         cnt_ff <= 4'h0;
         hit_ff <= 1'b0;
      end else begin
         el_ff <= el;
         last_ff <= o_dq;
         if (i_cs_n) begin
            cnt_ff <= 4'h0;
            hit_ff <= 1'b0;
         end else if (el[20:3] != el_ff[20:3]) begin
            cnt_ff <= 4'h1;
            hit_ff <= 1'b0;
         end else if (el != el_ff) begin
            cnt_ff <= 4'h1;
            hit_ff <= hit_ff | rdy;
         end else if (!rdy) begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (!i_cs_n && !i_we_n) cmd_ff <= i_wdata & mk;
   end
endmodule

// ===== tb/pfb_host_test.sv
// Bench for the page flash host driving the pin level flash model.
module pfb_host_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_b = 1'b0, half = 1'b0, req = 1'b0, wr = 1'b0, keep = 1'b0;
   logic [20:0] adr = 21'h00_0000;
   logic [31:0] wd = 32'h0000_0000, rdata, dout, doe, dq;
   logic rdy, vld, cs_n, oe_n, we_n, ws_n;
   logic [19:0] addr;
   int fail_count = 0, checks_done = 0, cycles = 0;
   wire logic [31:0] bus = (doe & dout) | (~doe & dq);
   pfb_host u_pfb_host (.i_ref_clk(clk), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_half_mode(half), .i_req(req),
      .i_req_write(wr), .i_req_addr(adr), .i_req_wdata(wd), .i_req_keep_select(keep), .o_req_ready(rdy),
      .o_rsp_valid(vld), .o_rsp_rdata(rdata), .o_chip_select_n(cs_n), .o_output_gate_n(oe_n),
      .o_write_strobe_n(we_n), .o_width_select_n(ws_n), .o_addr(addr), .o_data_out(dout), .o_data_oe(doe),
      .i_data_in(bus));
   pfb_flash_model u_pfb_flash_model (.i_ref_clk(clk), .i_rst_b(rst_b), .i_cs_n(cs_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_ws_n(ws_n), .i_addr(addr), .i_wdata(dout), .o_dq(dq));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   function automatic logic [31:0] word(input logic [19:0] a);
      return 32'hC3A0_0000 | {12'h000, a};
   endfunction
   task automatic op(input logic w, input logic [20:0] a, input logic [31:0] d, input logic k, output int n);
      @(posedge clk);
      #1;
      req = 1'b1;
      wr = w;
      adr = a;
      wd = d;
      keep = k;
      @(posedge clk);
      #1;
      req = 1'b0;
      n = 0;
      while (vld !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   task automatic t_page();
      int n0, n1;
      op(1'b0, 21'h10_1235, 32'h0000_0000, 1'b0, n0);
      chk(rdata, word(20'h0_1235), "boot read");
      op(1'b0, 21'h00_4560, 32'h0000_0000, 1'b1, n0);
      for (int i = 0; i < 3; i++) begin
         op(1'b0, 21'h00_4563 - 21'(i), 32'h0000_0000, 1'b1, n1);
         chk(rdata, word(20'h0_4563 - 20'(i)), "page word");
         chk(n1 + pfb_pkg::RANDOM_CYC - pfb_pkg::PAGE_CYC, n0, "hit time");
      end
      op(1'b0, 21'h00_4564, 32'h0000_0000, 1'b0, n1);
      chk(n1, n0, "new page time");
      op(1'b0, 21'h00_4565, 32'h0000_0000, 1'b1, n1);
      chk(n1, n0, "reselect time");
   endtask
   task automatic t_half();
      int n;
      logic [31:0] w;
      logic [20:0] a;
      half = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(ws_n, 1'b0, "width select");
      for (int e = 7; e >= 0; e--) begin
         a = 21'h00_2468 + 21'(e);
         op(1'b0, a, 32'h0000_0000, 1'b1, n);
         w = word(a[20:1]);
         chk(rdata, {16'h0000, a[0] ? w[31:16] : w[15:0]}, "half word");
      end
      half = 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_write();
      int n;
      op(1'b1, 21'h00_0555, 32'h5A5A_F0F0, 1'b0, n);
      chk(u_pfb_flash_model.cmd_ff, 32'h5A5A_F0F0, "write data");
      op(1'b0, 21'h00_0777, 32'h0000_0000, 1'b0, n);
      chk(rdata, word(20'h0_0777), "read after write");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst_b = 1'b1;
      t_page();
      t_half();
      t_write();
      wrap_up();
   end
endmodule
